// ---- fault_pkg.sv ----
`default_nettype none
package fault_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    // flash timing in milliseconds, converted to cycles at the board clock
    localparam int unsigned FLASH_ON_MS = 250;
    localparam int unsigned FLASH_OFF_MS = 250;
    localparam int unsigned FLASH_GAP_MS = 1500;
    localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
    localparam int unsigned FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
    localparam int unsigned FLASH_GAP_CYC = CLK_HZ / 1000 * FLASH_GAP_MS;
    localparam int unsigned TMR_W = 32;
    localparam int unsigned CODE_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned AIN_W = 14;
    localparam int unsigned NUM_AIN = 6;
    localparam int unsigned NUM_SPD = 2;
    localparam int unsigned SPD_W = 16;
    localparam int unsigned NUM_SER = 3;
    localparam int unsigned NUM_OUT = 6;
    localparam logic [NUM_OUT-1:0] OUT_SHUTDOWN = 6'h00;
    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
    localparam logic [CODE_W-1:0] CODE_CPU = 5'h01;
    localparam logic [CODE_W-1:0] CODE_BUS_EXC = 5'h02;
    localparam logic [CODE_W-1:0] CODE_RAM = 5'h03;
    localparam logic [CODE_W-1:0] CODE_LOCAL_WDOG = 5'h04;
    localparam logic [CODE_W-1:0] CODE_NONVOLATILE_BYTE_MEMORY = 5'h05;
    localparam logic [CODE_W-1:0] CODE_FLASH_PROG = 5'h06;
    localparam logic [CODE_W-1:0] CODE_KERNEL_WDOG = 5'h07;
    localparam logic [CODE_W-1:0] CODE_COMM_CTRL = 5'h0a;
    localparam logic [CODE_W-1:0] CODE_RTC = 5'h0b;
    localparam logic [CODE_W-1:0] CODE_TIMER_COPROCESSOR = 5'h0c;
    localparam logic [CODE_W-1:0] CODE_OS_MIN = 5'h14;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_PASS = 2'b01,
        ST_FAIL = 2'b11
    } diag_state_t;
endpackage
`default_nettype wire

// ---- lamp_flasher.sv ----
`default_nettype none
module lamp_flasher
    import fault_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    input wire logic [CODE_W-1:0] count_in,
    output logic lamp_out
);
    typedef enum logic [1:0] {
        FL_ON = 2'b00,
        FL_OFF = 2'b01,
        FL_GAP = 2'b11
    } flash_state_t;
    flash_state_t state_q;
    logic [TMR_W-1:0] tmr_q;
    logic [CODE_W-1:0] pulses_q;
    // group of equal pulses then a long dark pause (see R13)
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= FL_ON;
            tmr_q <= '0;
            pulses_q <= '0;
        end else if (!enable_in) begin
            state_q <= FL_ON;
            tmr_q <= '0;
            pulses_q <= '0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
            unique case (state_q)
                FL_ON: if (tmr_q >= TMR_W'(FLASH_ON_CYC - 1)) begin
                    tmr_q <= '0;
                    pulses_q <= pulses_q + 5'h1;
                    state_q <= (pulses_q + 5'h1 >= count_in) ? FL_GAP : FL_OFF;
                end
                FL_OFF: if (tmr_q >= TMR_W'(FLASH_OFF_CYC - 1)) begin
                    tmr_q <= '0;
                    state_q <= FL_ON;
                end
                FL_GAP: if (tmr_q >= TMR_W'(FLASH_GAP_CYC - 1)) begin
                    tmr_q <= '0;
                    pulses_q <= '0;
                    state_q <= FL_ON;
                end
                default: state_q <= FL_ON;
            endcase
        end
    end
    assign lamp_out = (state_q == FL_ON);
endmodule
`default_nettype wire

// ---- board_fault_indicator.sv ----
// Notes on behaviour
// (R01) lamp forced on while system reset is asserted.
// (R02) after each processor reset, lamp held on during diagnostics.
// (R03) failed diagnostics leave lamp steady or flashing, never dark.
// (R04) passing diagnostics turn the lamp off.
// (R05) flash codes 1..7: cpu, bus, ram, local wdog, nvmem, flash, kernel wdog.
// (R06) flash codes 10, 11, 12: comm controller, clock, timer coprocessor ram.
// (R07) codes 20 and up reserved for operating system errors.
// (R08) address switch must match configured module address or fault remains.
// (R09) analog and speed inputs flagged when above high or below low latch.
// (R10) three serial ports monitored, errors reported per port.
// (R11) software, hardware and expansion bus watchdogs supervise the processor.
// (R12) any supervision fault drives all outputs to shutdown.
// (R13) flash group of equal pulses followed by longer dark pause.
`default_nettype none
module board_fault_indicator
    import fault_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic cpu_reset_in,
    input wire logic diag_done_in,
    input wire logic diag_pass_in,
    input wire logic [CODE_W-1:0] diag_code_in,
    input wire logic os_error_in,
    input wire logic [CODE_W-1:0] os_code_in,
    input wire logic [ADDR_W-1:0] addr_switch_in,
    input wire logic [ADDR_W-1:0] module_addr_in,
    input wire logic [NUM_AIN*AIN_W-1:0] ain_value_in,
    input wire logic [NUM_AIN*AIN_W-1:0] ain_high_in,
    input wire logic [NUM_AIN*AIN_W-1:0] ain_low_in,
    input wire logic [NUM_SPD*SPD_W-1:0] spd_value_in,
    input wire logic [NUM_SPD*SPD_W-1:0] spd_high_in,
    input wire logic [NUM_SPD*SPD_W-1:0] spd_low_in,
    input wire logic [NUM_SER-1:0] ser_err_in,
    input wire logic [NUM_SER-1:0] ser_err_clr_in,
    input wire logic sw_wdog_fault_in,
    input wire logic hw_wdog_fault_in,
    input wire logic bus_wdog_fault_in,
    input wire logic [NUM_OUT-1:0] out_request_in,
    output logic fault_lamp_out,
    output logic diag_ok_out,
    output logic [CODE_W-1:0] fail_code_out,
    output logic addr_mismatch_out,
    output logic [NUM_AIN-1:0] ain_fault_out,
    output logic [NUM_SPD-1:0] spd_fault_out,
    output logic [NUM_SER-1:0] ser_fault_out,
    output logic [2:0] wdog_fault_out,
    output logic shutdown_out,
    output logic [NUM_OUT-1:0] outputs_out
);
    diag_state_t state_q;
    logic [CODE_W-1:0] code_q;
    logic mismatch_q;
    logic flash_lamp;
    logic flash_en;
    logic code_known;
    logic [NUM_AIN-1:0] ain_fault_q;
    logic [NUM_SPD-1:0] spd_fault_q;
    logic [NUM_SER-1:0] ser_fault_q;
    logic [2:0] wdog_q;
    logic shutdown_q;
    logic [NUM_OUT-1:0] outputs_q;

    // hardware diagnostic codes; anything else below the reserved os codes falls back to a steady lamp
    function automatic logic is_hw_code(input logic [CODE_W-1:0] c);
        unique case (c)
            CODE_CPU, CODE_BUS_EXC, CODE_RAM, CODE_LOCAL_WDOG,
            CODE_NONVOLATILE_BYTE_MEMORY, CODE_FLASH_PROG, CODE_KERNEL_WDOG: return 1'b1; // see R05
            CODE_COMM_CTRL, CODE_RTC, CODE_TIMER_COPROCESSOR: return 1'b1; // see R06
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic out_of_band(input logic [SPD_W-1:0] v, input logic [SPD_W-1:0] hi,
                                         input logic [SPD_W-1:0] lo);
        return (v > hi) || (v < lo);
    endfunction

    // diagnostic state; processor reset reopens the sequence (see R02)
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_INIT;
            code_q <= CODE_NONE;
            mismatch_q <= 1'b0;
        end else if (cpu_reset_in) begin
            state_q <= ST_INIT; // see R02
            code_q <= CODE_NONE;
            mismatch_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_INIT: if (diag_done_in) begin
                    mismatch_q <= (addr_switch_in != module_addr_in); // see R08
                    if (diag_pass_in && addr_switch_in == module_addr_in) begin
                        state_q <= ST_PASS; // see R04
                    end else begin
                        state_q <= ST_FAIL; // see R03
                        code_q <= diag_pass_in ? CODE_NONE : diag_code_in;
                    end
                end
                ST_PASS: if (os_error_in && os_code_in >= CODE_OS_MIN) begin
                    // only reserved codes may come from the operating system
                    state_q <= ST_FAIL; // see R07
                    code_q <= os_code_in;
                end
                ST_FAIL: begin
                end
                default: state_q <= ST_INIT;
            endcase
        end
    end

    always_comb begin
        code_known = is_hw_code(code_q) || (code_q >= CODE_OS_MIN); // see R07
        flash_en = (state_q == ST_FAIL) && code_known;
    end

    lamp_flasher i_lamp_flasher (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .enable_in(flash_en),
        .count_in(code_q),
        .lamp_out(flash_lamp)
    );

    // lamp comes up lit out of reset: state resets to init (see R01)
    always_comb begin
        unique case (state_q)
            ST_INIT: fault_lamp_out = 1'b1; // see R02
            ST_PASS: fault_lamp_out = 1'b0; // see R04
            ST_FAIL: fault_lamp_out = flash_en ? flash_lamp : 1'b1; // see R03
            default: fault_lamp_out = 1'b1;
        endcase
        if (!resetn_in) begin
            fault_lamp_out = 1'b1; // see R01
        end
    end

    // latch limits: a crossing stays flagged until a processor reset with the value back inside its limits; crossing wins over reset
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AIN; gi++) begin : g_ain
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ain_fault_q[gi] <= 1'b0;
                end else if (out_of_band(SPD_W'(ain_value_in[gi*AIN_W +: AIN_W]),
                                         SPD_W'(ain_high_in[gi*AIN_W +: AIN_W]),
                                         SPD_W'(ain_low_in[gi*AIN_W +: AIN_W]))) begin
                    ain_fault_q[gi] <= 1'b1; // see R09
                end else if (cpu_reset_in) begin
                    ain_fault_q[gi] <= 1'b0;
                end
            end
        end
        for (gi = 0; gi < NUM_SPD; gi++) begin : g_spd
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    spd_fault_q[gi] <= 1'b0;
                end else if (out_of_band(spd_value_in[gi*SPD_W +: SPD_W], spd_high_in[gi*SPD_W +: SPD_W],
                                         spd_low_in[gi*SPD_W +: SPD_W])) begin
                    spd_fault_q[gi] <= 1'b1; // see R09
                end else if (cpu_reset_in) begin
                    spd_fault_q[gi] <= 1'b0;
                end
            end
        end
        for (gi = 0; gi < NUM_SER; gi++) begin : g_ser
            // set wins over clear so a same-cycle error is not lost
            always_ff @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ser_fault_q[gi] <= 1'b0;
                end else if (ser_err_in[gi]) begin
                    ser_fault_q[gi] <= 1'b1; // see R10
                end else if (ser_err_clr_in[gi]) begin
                    ser_fault_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // watchdog faults are sticky until system reset; no software clear
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdog_q <= 3'h0;
        end else begin
            wdog_q <= wdog_q | {bus_wdog_fault_in, hw_wdog_fault_in, sw_wdog_fault_in}; // see R11
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shutdown_q <= 1'b1;
            outputs_q <= OUT_SHUTDOWN;
        end else begin
            shutdown_q <= |wdog_q;
            outputs_q <= (|wdog_q) ? OUT_SHUTDOWN : out_request_in; // see R12
        end
    end

    assign diag_ok_out = (state_q == ST_PASS);
    assign fail_code_out = code_q;
    assign addr_mismatch_out = mismatch_q;
    assign ain_fault_out = ain_fault_q;
    assign spd_fault_out = spd_fault_q;
    assign ser_fault_out = ser_fault_q;
    assign wdog_fault_out = wdog_q;
    assign shutdown_out = shutdown_q;
    assign outputs_out = outputs_q;

    property p_lamp_init;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_INIT |-> fault_lamp_out;
    endproperty
    a_lamp_init: assert property (p_lamp_init) else $error("lamp dark during diagnostics"); // see R02

    property p_cpu_reset;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        cpu_reset_in |=> state_q == ST_INIT && fault_lamp_out;
    endproperty
    a_cpu_reset: assert property (p_cpu_reset) else $error("processor reset did not relight lamp"); // see R02

    sequence s_fail_entry;
        state_q == ST_INIT && diag_done_in && !diag_pass_in && !cpu_reset_in;
    endsequence
    property p_fail_stays;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        s_fail_entry ##1 (!cpu_reset_in) [*3] |-> state_q == ST_FAIL;
    endproperty
    a_fail_stays: assert property (p_fail_stays) else $error("failure state left without reset"); // see R03

    property p_fail_steady;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_FAIL && !is_hw_code(code_q) && code_q < CODE_OS_MIN |-> fault_lamp_out && !flash_en;
    endproperty
    a_fail_steady: assert property (p_fail_steady) else $error("unflashed failure lamp dark"); // see R03

    property p_pass_off;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_INIT && diag_done_in && diag_pass_in && addr_switch_in == module_addr_in
            && !cpu_reset_in |=> !fault_lamp_out && diag_ok_out;
    endproperty
    a_pass_off: assert property (p_pass_off) else $error("pass did not darken lamp"); // see R04

    property p_code_hold;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        s_fail_entry |=> fail_code_out == $past(diag_code_in);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("failure code not captured"); // see R05

    property p_code_ten;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_INIT && diag_done_in && !diag_pass_in && !cpu_reset_in && diag_code_in == CODE_COMM_CTRL
            |=> flash_en && fault_lamp_out;
    endproperty
    a_code_ten: assert property (p_code_ten) else $error("code ten not flashed"); // see R06

    property p_os_low;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_PASS && !cpu_reset_in && !(os_error_in && os_code_in >= CODE_OS_MIN) |=> state_q == ST_PASS;
    endproperty
    a_os_low: assert property (p_os_low) else $error("unreserved os code accepted"); // see R07

    property p_addr;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        state_q == ST_INIT && diag_done_in && !cpu_reset_in && addr_switch_in != module_addr_in
            |=> state_q == ST_FAIL ##1 (fault_lamp_out || flash_en);
    endproperty
    a_addr: assert property (p_addr) else $error("address mismatch cleared fault"); // see R08

    property p_ser;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        ser_err_in[0] |=> ser_fault_out[0];
    endproperty
    a_ser: assert property (p_ser) else $error("serial error not reported"); // see R10

    property p_wdog;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        hw_wdog_fault_in |=> wdog_fault_out[1] ##1 shutdown_out && outputs_out == OUT_SHUTDOWN;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog fault did not shut outputs"); // see R12

    // no disable here: the reset itself is what is being watched
    property p_lamp_reset;
        @(posedge clk_sys_in)
        !resetn_in |-> fault_lamp_out;
    endproperty
    a_lamp_reset: assert property (p_lamp_reset) else $error("lamp dark in system reset"); // see R01

    property p_ain_high;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        ain_value_in[2*AIN_W +: AIN_W] > ain_high_in[2*AIN_W +: AIN_W] |=> ain_fault_out[2];
    endproperty
    a_ain_high: assert property (p_ain_high) else $error("analog high crossing not flagged"); // see R09

    property p_spd_low;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        spd_value_in[SPD_W +: SPD_W] < spd_low_in[SPD_W +: SPD_W] |=> spd_fault_out[1];
    endproperty
    a_spd_low: assert property (p_spd_low) else $error("speed low crossing not flagged"); // see R09

    property p_wdog_sw;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        sw_wdog_fault_in |=> wdog_fault_out[0] ##1 shutdown_out;
    endproperty
    a_wdog_sw: assert property (p_wdog_sw) else $error("software watchdog fault missed"); // see R11

    property p_wdog_bus;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        bus_wdog_fault_in |=> wdog_fault_out[2] ##1 shutdown_out;
    endproperty
    a_wdog_bus: assert property (p_wdog_bus) else $error("bus watchdog fault missed"); // see R11

    property p_out_follow;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wdog_fault_out == 3'h0 |=> !shutdown_out && outputs_out == $past(out_request_in);
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("outputs held off without fault"); // see R12
endmodule
`default_nettype wire

// ---- diag_cpu_model.sv ----
`default_nettype none
module diag_cpu_model
    import fault_pkg::*;
(
    input wire logic clk_sys_in,
    output logic cpu_reset_out,
    output logic diag_done_out,
    output logic diag_pass_out,
    output logic [CODE_W-1:0] diag_code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cpu_reset_out = 1'b0;
        diag_done_out = 1'b0;
        diag_pass_out = 1'b1;
        diag_code_out = 5'h1f;
    end
    // processor reset, diagnostics restart behind it
    task automatic restart();
        @(negedge clk_sys_in);
        cpu_reset_out = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        cpu_reset_out = 1'b0;
    endtask
    // one result per restart; lines scrambled after so no stale value lingers
    task automatic report(input logic pass, input logic [CODE_W-1:0] code);
        @(negedge clk_sys_in);
        diag_done_out = 1'b1;
        diag_pass_out = pass;
        diag_code_out = code;
        @(negedge clk_sys_in);
        diag_done_out = 1'b0;
        diag_pass_out = ~pass;
        diag_code_out = ~code;
    endtask
endmodule
`default_nettype wire

// ---- board_fault_indicator_test.sv ----
`default_nettype none
module board_fault_indicator_test
    import fault_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cpu_reset, diag_done, diag_pass, os_error_in, lamp, diag_ok, mism, shut;
    logic [CODE_W-1:0] diag_code, os_code_in, fail_code;
    logic [ADDR_W-1:0] addr_sw_in, mod_addr_in;
    logic [NUM_AIN*AIN_W-1:0] ain_v, ain_h, ain_l;
    logic [NUM_SPD*SPD_W-1:0] spd_v, spd_h, spd_l;
    logic [NUM_SER-1:0] ser_err, ser_clr, ser_f;
    logic [2:0] wdog_in, wdog_f;
    logic [NUM_OUT-1:0] req, outs;
    logic [NUM_AIN-1:0] ain_f;
    logic [NUM_SPD-1:0] spd_f;
    int n_fail = 0;
    int compares = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    diag_cpu_model i_diag_cpu_model(.clk_sys_in(clk_sys_in), .cpu_reset_out(cpu_reset), .diag_done_out(diag_done),
        .diag_pass_out(diag_pass), .diag_code_out(diag_code));
    board_fault_indicator i_board_fault_indicator(.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .cpu_reset_in(cpu_reset), .diag_done_in(diag_done), .diag_pass_in(diag_pass), .diag_code_in(diag_code),
        .os_error_in(os_error_in), .os_code_in(os_code_in), .addr_switch_in(addr_sw_in),
        .module_addr_in(mod_addr_in), .ain_value_in(ain_v), .ain_high_in(ain_h), .ain_low_in(ain_l),
        .spd_value_in(spd_v), .spd_high_in(spd_h), .spd_low_in(spd_l), .ser_err_in(ser_err),
        .ser_err_clr_in(ser_clr), .sw_wdog_fault_in(wdog_in[0]), .hw_wdog_fault_in(wdog_in[1]),
        .bus_wdog_fault_in(wdog_in[2]), .out_request_in(req), .fault_lamp_out(lamp), .diag_ok_out(diag_ok),
        .fail_code_out(fail_code), .addr_mismatch_out(mism), .ain_fault_out(ain_f), .spd_fault_out(spd_f),
        .ser_fault_out(ser_f), .wdog_fault_out(wdog_f), .shutdown_out(shut), .outputs_out(outs));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic do_reset();
        @(negedge clk_sys_in);
        resetn_in = 1'b0;
        wdog_in = 3'h0;
        settle(5);
        chk("lamp in reset", lamp, 1);
        chk("shutdown in reset", shut, 1);
        chk("outputs in reset", outs, 0);
        resetn_in = 1'b1;
    endtask
    // slow processor: several cycles pass between restart and result
    task automatic run_diag(input logic pass, input logic [CODE_W-1:0] code);
        i_diag_cpu_model.restart();
        settle(4);
        chk("lamp during diag", lamp, 1);
        chk("ok during diag", diag_ok, 0);
        i_diag_cpu_model.report(pass, code);
        settle(1);
    endtask
    task automatic t_pass();
        int i;
        run_diag(1'b1, 5'h00);
        for (i = 0; i < 4 && lamp !== 1'b0; i++)
            settle(1);
        if (i == 4) begin
            n_fail++;
            conclude();
        end
        chk("lamp after pass", lamp, 0);
        chk("ok after pass", diag_ok, 1);
        chk("outputs follow request", outs, req);
        chk("no shutdown", shut, 0);
        $display("test pass done");
    endtask
    task automatic t_fail_codes();
        logic [CODE_W-1:0] codes [11] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0a, 5'h0b,
                                          5'h0c, 5'h08};
        foreach (codes[i]) begin
            run_diag(1'b0, codes[i]);
            chk("fail code", fail_code, codes[i]);
            settle(20);
            chk("lamp after fail", lamp, 1);
            chk("ok after fail", diag_ok, 0);
        end
        $display("test fail codes done");
    endtask
    task automatic t_addr();
        mod_addr_in = 8'h2b;
        run_diag(1'b1, 5'h00);
        chk("mismatch flag", mism, 1);
        chk("lamp on mismatch", lamp, 1);
        chk("ok on mismatch", diag_ok, 0);
        mod_addr_in = 8'h2a;
        $display("test address done");
    endtask
    task automatic t_os();
        t_pass();
        os_code_in = 5'h13;
        os_error_in = 1'b1;
        settle(1);
        os_error_in = 1'b0;
        settle(1);
        chk("os code 19 ignored", diag_ok, 1);
        chk("os code 19 not latched", fail_code, 0);
        os_code_in = 5'h14;
        os_error_in = 1'b1;
        settle(1);
        os_error_in = 1'b0;
        settle(1);
        chk("os code 20", fail_code, 5'h14);
        chk("lamp os error", lamp, 1);
        $display("test os done");
    endtask
    // equal to a limit is not a crossing
    task automatic t_limits();
        ain_v[2*AIN_W+:AIN_W] = 14'h2001;
        ain_v[0+:AIN_W] = 14'h2000;
        ain_v[4*AIN_W+:AIN_W] = 14'h00ff;
        spd_v[SPD_W+:SPD_W] = 16'h000f;
        spd_v[0+:SPD_W] = 16'h0010;
        settle(2);
        chk("analog faults", ain_f, 6'h14);
        chk("speed faults", spd_f, 2'h2);
        ain_v = {NUM_AIN{14'h1000}};
        spd_v = {NUM_SPD{16'h1000}};
        settle(1);
        chk("analog sticky", ain_f, 6'h14);
        i_diag_cpu_model.restart();
        settle(2);
        chk("analog cleared", ain_f, 0);
        chk("speed cleared", spd_f, 0);
        $display("test limits done");
    endtask
    task automatic t_serial();
        for (int i = 0; i < NUM_SER; i++) begin
            ser_err = 3'h1 << i;
            ser_clr = (i == 0) ? 3'h1 : 3'h0;
            settle(1);
            ser_err = 3'h0;
            ser_clr = 3'h0;
            settle(1);
            chk("serial set", ser_f, 3'h1 << i);
            ser_clr = 3'h7;
            settle(1);
            ser_clr = 3'h0;
            settle(1);
            chk("serial clear", ser_f, 0);
        end
        $display("test serial done");
    endtask
    task automatic t_wdog();
        for (int i = 0; i < 3; i++) begin
            do_reset();
            settle(2);
            wdog_in = 3'h1 << i;
            settle(2);
            chk("watchdog flag", wdog_f, 3'h1 << i);
            chk("shutdown", shut, 1);
            chk("outputs off", outs, OUT_SHUTDOWN);
        end
        $display("test watchdog done");
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        n_fail++;
        conclude();
    end
    initial begin
        {os_error_in, ser_err, ser_clr, wdog_in, os_code_in} = '0;
        addr_sw_in = 8'h2a;
        mod_addr_in = 8'h2a;
        req = 6'h2d;
        ain_v = {NUM_AIN{14'h1000}};
        ain_h = {NUM_AIN{14'h2000}};
        ain_l = {NUM_AIN{14'h0100}};
        spd_v = {NUM_SPD{16'h1000}};
        spd_h = {NUM_SPD{16'h8000}};
        spd_l = {NUM_SPD{16'h0010}};
        do_reset();
        t_pass();
        t_fail_codes();
        t_addr();
        t_os();
        t_limits();
        t_serial();
        t_wdog();
        conclude();
    end
endmodule
`default_nettype wire
